// file: logic/l1dc_pkg.sv
// Shared constants, carriers and states for the level one data cache.
package l1dc_pkg;
	// ------------------------------------------------------------------
	// Geometry and address fields
	// ------------------------------------------------------------------
	localparam int CACHE_BYTES = 16384;
	localparam int LINE_BYTES  = 64;
	localparam int NUM_WAYS    = 2;
	localparam int NUM_SETS    = 128;
	localparam int NUM_BANKS   = 8;
	localparam int SET_LSB     = 6;
	localparam int SET_MSB     = 12;
	localparam int TAG_LSB     = 13;
	localparam int BANK_LSB    = 2;
	localparam int BANK_MSB    = 4;
	localparam int HALF_BIT    = 5;
	localparam int DW_LSB      = 3;
	localparam int TAG_W       = 32 - TAG_LSB;
	localparam int SET_W       = SET_MSB - SET_LSB + 1;
	localparam int LINE_W      = 32 - SET_LSB;
	localparam int ROW_W       = SET_W + 2;
	localparam int HALF_LINE_W = LINE_BYTES * 4;
	localparam logic [2:0] LAST_BEAT = 3'h7;
	// ------------------------------------------------------------------
	// Write buffer and miss timing
	// ------------------------------------------------------------------
	localparam logic [2:0] WB_DEPTH  = 3'h4;
	localparam logic [3:0] PEN_SRAM  = 4'h6;
	localparam logic [3:0] PEN_CACHE = 4'h8;
	localparam logic [3:0] PEN_OVL   = 4'h2;
	// ------------------------------------------------------------------
	// Carriers and states
	// ------------------------------------------------------------------
	typedef struct packed {
		logic        valid;
		logic        write;
		logic        nalign;
		logic        l2_sram;
		logic [31:0] addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} l1dc_acc_s;

	typedef struct packed {
		logic [31-DW_LSB:0] dw;
		logic               sram;
		logic [7:0]         be;
		logic [63:0]        data;
	} l1dc_wb_s;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,
		ST_DRAIN = 4'h2,
		ST_VICT  = 4'h4,
		ST_FILL  = 4'h8
	} l1dc_state_e;
endpackage

// file: logic/l1dc_top.sv
// Two-way level one data cache with banked data, victim buffer and write buffer.
// Function
// R1: 16 KB, two ways, 64-byte lines, 128 sets.
// R2: Offset 5-0, set 12-6, tag 31-13.
// R3: Hit needs matching tag in valid way.
// R4: Allocate on read miss only.
// R5: Replace least recent way, invalid first.
// R6: Victim written back only after cacheable fill.
// R7: Eight single-ported 32-bit banks, bits 4-2.
// R8: Same-bank pair stalls one cycle.
// R9: Listed same-bank cases never stall.
// R10: Parallel read and write same bank stall.
// R11: Two accesses per cycle, hits unstalled.
// R12: Isolated miss stalls 6 or 8 cycles.
// R13: Same-line misses pay one penalty.
// R14: Misses wait for pending victim writeback.
// R15: Overlap two misses, 2 extra cycles.
// R16: Four-entry 64-bit write buffer.
// R17: Write miss stalls only while buffer full; the code also stalls it while a victim writeback is pending.
// R18: Read miss waits for empty write buffer.
// R19: Second level takes write each free cycle.
// R20: Merge fresh unpresented double-word SRAM writes.
// R21: Stall until line fill completes.
`timescale 1ns/10ps
module l1dc_top
	import l1dc_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire l1dc_acc_s             acc0,
	input  wire l1dc_acc_s             acc1,
	output logic                       stall,
	output logic                       rvalid0,
	output logic [31:0]                rdata0,
	output logic                       rvalid1,
	output logic [31:0]                rdata1,
	output logic                       wb_valid,
	output l1dc_wb_s                   wb_out,
	input  wire logic                  wb_ready,
	output logic                       fill_req_valid,
	output logic [LINE_W-1:0]          fill_req_line,
	input  wire logic                  fill_req_ready,
	input  wire logic                  fill_beat_valid,
	input  wire logic [63:0]           fill_beat_data,
	input  wire logic                  fill_cacheable,
	input  wire logic                  fill_sram,
	output logic                       vic_valid,
	output logic [LINE_W-1:0]          vic_line,
	output logic [LINE_BYTES*8-1:0]    vic_data,
	input  wire logic                  vic_ready
);
	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic [TAG_W-1:0]    tag_reg [NUM_WAYS][NUM_SETS]; // R1
	logic [NUM_SETS-1:0] vld_reg [NUM_WAYS];
	logic [NUM_SETS-1:0] dirty_reg [NUM_WAYS];
	logic [NUM_SETS-1:0] lru_reg;
	l1dc_wb_s            wbm [4];
	logic [1:0]          wr_reg, rd_reg;
	logic [2:0]          cnt_reg;
	logic                fresh_reg, conf_reg, vic_pend_reg;
	l1dc_state_e         st_reg, st_next;
	logic [LINE_W-1:0]   mq_line [2];
	logic                mq_way [2];
	logic                mq_port [2];
	logic                two_reg, vdirty_reg, vhalf_reg, sram_reg;
	logic [1:0]          iss_reg, ret_reg;
	logic [2:0]          beat_reg;
	logic [3:0]          pen_reg;
	logic [1:0]          nc_vld_reg;
	logic [31:0]         nc_word_reg [2];
	logic [1:0]          rvalid_reg;
	logic [31:0]         rdata_reg [2];
	// ------------------------------------------------------------------
	// Per-port lookup
	// ------------------------------------------------------------------
	l1dc_acc_s          acc [2];
	logic [SET_W-1:0]   pset [2];
	logic [1:0]         hitw [2];
	logic [1:0]         hit, ehit, rmiss, wmiss, vway, vdirty, tok, serve;
	logic [ROW_W-1:0]   prow [2];
	logic [2:0]         pbank [2];
	l1dc_wb_s           went [2];
	logic [7:0][31:0]   bank_q;
	wire  [1:0]         tail = wr_reg - 2'h1;
	assign acc[0] = acc0;
	assign acc[1] = acc1;

	for (genvar p = 0; p < 2; p++) begin : g_port
		wire [31:0] a = acc[p].addr;
		assign pset[p] = a[SET_MSB:SET_LSB]; // R2
		assign hitw[p] = {vld_reg[1][pset[p]] && tag_reg[1][pset[p]] == a[31:TAG_LSB],
			vld_reg[0][pset[p]] && tag_reg[0][pset[p]] == a[31:TAG_LSB]}; // R3
		assign hit[p] = |hitw[p];
		assign ehit[p] = hit[p] || nc_vld_reg[p];
		assign rmiss[p] = acc[p].valid && !acc[p].write && !ehit[p];
		assign wmiss[p] = acc[p].valid && acc[p].write && !hit[p]; // R4
		assign prow[p] = {hitw[p][1], pset[p], a[HALF_BIT]};
		assign pbank[p] = a[BANK_MSB:BANK_LSB]; // R7
		assign vway[p] = !vld_reg[0][pset[p]] ? 1'b0 : (!vld_reg[1][pset[p]] ? 1'b1 : lru_reg[pset[p]]); // R5
		assign vdirty[p] = vld_reg[vway[p]][pset[p]] && dirty_reg[vway[p]][pset[p]];
		assign went[p] = '{a[31:DW_LSB], acc[p].l2_sram, a[2] ? {acc[p].be, 4'h0} : {4'h0, acc[p].be},
			{2{acc[p].wdata}}};
		assign tok[p] = fresh_reg && cnt_reg > 3'h1 && wbm[tail].dw == went[p].dw && wbm[tail].sram
			&& went[p].sram; // R20
	end

	function automatic l1dc_wb_s wmerge(l1dc_wb_s x, l1dc_wb_s y);
		l1dc_wb_s r;
		r = x;
		for (int i = 0; i < 8; i++) begin
			if (y.be[i]) begin
				r.data[8*i+:8] = y.data[8*i+:8];
			end
		end
		r.be = x.be | y.be;
		return r;
	endfunction
	// ------------------------------------------------------------------
	// Bank conflicts and stall
	// ------------------------------------------------------------------
	wire same_bank = acc0.valid && acc1.valid && pbank[0] == pbank[1];
	wire same_word = acc0.addr[31:2] == acc1.addr[31:2];
	wire disjoint  = (acc0.be & acc1.be) == 4'h0;
	wire exempt    = (acc0.write == acc1.write && same_word && (!acc0.write || disjoint))
		|| wmiss[0] || wmiss[1] || acc1.nalign; // R9
	wire conflict  = same_bank && ehit[0] && ehit[1] && !exempt; // R8 R10
	wire conf_stall = conflict && !conf_reg; // R8
	wire rmiss_any = |rmiss;

	// Merge decisions are made before the buffer-full check so a merge needs no slot.
	wire pair = wmiss[0] && wmiss[1] && went[0].dw == went[1].dw && went[0].sram && went[1].sram; // R20
	wire mrg0 = wmiss[0] && tok[0];
	wire mrg1 = wmiss[1] && !wmiss[0] && tok[1];
	wire new0 = wmiss[0] && !mrg0;
	wire new1 = wmiss[1] && !pair && !mrg1;
	wire [2:0] need = {2'h0, new0} + {2'h0, new1};
	wire [2:0] free = WB_DEPTH - cnt_reg; // R16
	wire wstall = (wmiss[0] || wmiss[1]) && (need > free || vic_pend_reg); // R17 R14
	wire go = st_reg == ST_IDLE && !rmiss_any && !wstall; // R21
	wire pop = wb_valid && wb_ready; // R19
	assign serve[0] = go && acc0.valid && !conf_reg;
	assign serve[1] = go && acc1.valid && !conf_stall;
	assign stall = !go || conf_stall; // R11
	// ------------------------------------------------------------------
	// Miss engine
	// ------------------------------------------------------------------
	wire       first  = !rmiss[0];
	wire       drained = cnt_reg == 3'h0 && !vic_pend_reg; // R18 R14
	wire [1:0] nreq   = two_reg ? 2'h2 : 2'h1;
	wire       fdone  = ret_reg == nreq; // R21
	wire [3:0] pen_min = (sram_reg ? PEN_SRAM : PEN_CACHE) + (two_reg ? PEN_OVL : 4'h0); // R12 R15
	wire       pen_ok = pen_reg >= pen_min - 4'h1;
	wire       rslot  = ret_reg[0];
	wire       beat   = st_reg == ST_FILL && fill_beat_valid;
	wire       inst   = beat && fill_cacheable && beat_reg == LAST_BEAT;
	wire [LINE_W-1:0] fline = mq_line[rslot];
	wire [ROW_W-1:0]  frow = {mq_way[rslot], fline[SET_W-1:0], beat_reg[2]};
	wire [31:0] rq_addr = acc[mq_port[rslot]].addr;
	assign fill_req_valid = st_reg == ST_FILL && iss_reg != nreq;
	assign fill_req_line = mq_line[iss_reg[0]];

	always_comb begin
		st_next = st_reg;
		case (st_reg)
			ST_IDLE: if (rmiss_any) begin
				st_next = ST_DRAIN;
			end
			ST_DRAIN: if (drained) begin
				st_next = vdirty[first] ? ST_VICT : ST_FILL;
			end
			ST_VICT: if (vhalf_reg) begin
				st_next = ST_FILL;
			end
			ST_FILL: if (fdone && pen_ok) begin
				st_next = ST_IDLE; // R12
			end
			default: st_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg <= ST_IDLE;
			pen_reg <= 4'h0;
			vhalf_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			pen_reg <= (st_reg == ST_IDLE) ? 4'h1 : (pen_reg == 4'hF ? pen_reg : pen_reg + 4'h1);
			vhalf_reg <= st_reg == ST_VICT && !vhalf_reg;
		end
	end

	// Same-line pair needs one fill; the second port then hits on replay.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			two_reg <= 1'b0;
			vdirty_reg <= 1'b0;
			iss_reg <= 2'h0;
			ret_reg <= 2'h0;
		end else if (st_reg == ST_DRAIN && drained) begin
			two_reg <= rmiss[0] && rmiss[1] && pset[0] != pset[1] && !vdirty[1]; // R15 R13
			vdirty_reg <= vdirty[first];
			iss_reg <= 2'h0;
			ret_reg <= 2'h0;
		end else begin
			iss_reg <= iss_reg + {1'b0, fill_req_valid && fill_req_ready};
			ret_reg <= ret_reg + {1'b0, beat && beat_reg == LAST_BEAT};
		end
	end

	always_ff @(posedge clk) begin
		if (st_reg == ST_DRAIN && drained) begin
			mq_line[0] <= acc[first].addr[31:SET_LSB];
			mq_way[0] <= vway[first];
			mq_port[0] <= first;
			mq_line[1] <= acc1.addr[31:SET_LSB];
			mq_way[1] <= vway[1];
			mq_port[1] <= 1'b1;
			vic_line <= {tag_reg[vway[first]][pset[first]], pset[first]};
		end
		if (st_reg == ST_VICT) begin
			vic_data[vhalf_reg*HALF_LINE_W+:HALF_LINE_W] <= bank_q;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			beat_reg <= 3'h0;
			sram_reg <= 1'b0;
			nc_vld_reg <= 2'h0;
			vic_pend_reg <= 1'b0;
		end else begin
			beat_reg <= beat_reg + {2'h0, beat};
			if (beat) begin
				sram_reg <= fill_sram;
			end
			nc_vld_reg <= nc_vld_reg & ~serve;
			if (beat && !fill_cacheable && beat_reg == rq_addr[5:3]) begin
				nc_vld_reg[mq_port[rslot]] <= 1'b1;
			end
			if (inst && rslot == 1'b0 && vdirty_reg) begin
				vic_pend_reg <= 1'b1; // R6
			end else if (vic_pend_reg && vic_ready) begin
				vic_pend_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (beat && !fill_cacheable && beat_reg == rq_addr[5:3]) begin
			nc_word_reg[mq_port[rslot]] <= fill_beat_data[32*rq_addr[2]+:32];
		end
		if (inst) begin
			tag_reg[mq_way[rslot]][fline[SET_W-1:0]] <= fline[LINE_W-1:SET_W]; // R4
		end
	end
	assign vic_valid = vic_pend_reg;
	// ------------------------------------------------------------------
	// Line state: valid, dirty, LRU
	// ------------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			vld_reg <= '{default: '0};
			dirty_reg <= '{default: '0};
			lru_reg <= '0;
		end else begin
			for (int p = 0; p < 2; p++) begin
				if (serve[p] && hit[p]) begin
					lru_reg[pset[p]] <= !hitw[p][1]; // R5
					if (acc[p].write) begin
						dirty_reg[hitw[p][1]][pset[p]] <= 1'b1;
					end
				end
			end
			if (inst) begin
				vld_reg[mq_way[rslot]][fline[SET_W-1:0]] <= 1'b1;
				dirty_reg[mq_way[rslot]][fline[SET_W-1:0]] <= 1'b0;
				lru_reg[fline[SET_W-1:0]] <= !mq_way[rslot];
			end
		end
	end
	// ------------------------------------------------------------------
	// Data banks and read data
	// ------------------------------------------------------------------
	for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
		logic [31:0] mem [1<<ROW_W];
		wire fw = beat && fill_cacheable && beat_reg[1:0] == 2'(b >> 1);
		wire w0 = serve[0] && acc0.write && hit[0] && pbank[0] == 3'(b);
		wire w1 = serve[1] && acc1.write && hit[1] && pbank[1] == 3'(b);
		wire [ROW_W-1:0] wrow = fw ? frow : (w0 ? prow[0] : prow[1]);
		// Port 1 bytes win where its lanes are enabled; port 0 fills the remaining lanes of a shared word.
		wire [31:0] m1 = {{8{acc1.be[3]}}, {8{acc1.be[2]}}, {8{acc1.be[1]}}, {8{acc1.be[0]}}};
		wire [31:0] pd = w1 ? ((acc1.wdata & m1) | (acc0.wdata & ~m1)) : acc0.wdata;
		wire [31:0] wd = fw ? fill_beat_data[32*(b%2)+:32] : pd;
		wire [3:0]  wbe = fw ? 4'hF : ((w0 ? acc0.be : 4'h0) | (w1 ? acc1.be : 4'h0));
		wire        r0 = serve[0] && !acc0.write && pbank[0] == 3'(b);
		wire [ROW_W-1:0] rrow = st_reg == ST_VICT ? {mq_way[0], mq_line[0][SET_W-1:0], vhalf_reg}
			: (r0 ? prow[0] : prow[1]);
		assign bank_q[b] = mem[rrow]; // R7
		always_ff @(posedge clk) begin
			for (int i = 0; i < 4; i++) begin
				if ((fw || w0 || w1) && wbe[i]) begin
					mem[wrow][8*i+:8] <= wd[8*i+:8];
				end
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rvalid_reg <= 2'h0;
			conf_reg <= 1'b0;
		end else begin
			rvalid_reg <= serve & {!acc1.write, !acc0.write};
			conf_reg <= conf_stall; // R8
		end
	end

	always_ff @(posedge clk) begin
		for (int p = 0; p < 2; p++) begin
			if (serve[p]) begin
				rdata_reg[p] <= nc_vld_reg[p] ? nc_word_reg[p] : bank_q[pbank[p]];
			end
		end
	end
	assign {rvalid1, rvalid0} = rvalid_reg;
	assign rdata0 = rdata_reg[0];
	assign rdata1 = rdata_reg[1];
	// ------------------------------------------------------------------
	// Write buffer
	// ------------------------------------------------------------------
	wire l1dc_wb_s e1x = pair ? went[1] : '0;
	always_ff @(posedge clk) begin
		if (go && mrg0) begin
			wbm[tail] <= wmerge(wmerge(wbm[tail], went[0]), e1x); // R20
		end
		if (go && new0) begin
			wbm[wr_reg] <= wmerge(went[0], e1x);
		end
		if (go && mrg1) begin
			wbm[tail] <= wmerge(wbm[tail], went[1]);
		end
		if (go && new1) begin
			wbm[2'(wr_reg + {1'b0, new0})] <= went[1];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_reg <= 2'h0;
			rd_reg <= 2'h0;
			cnt_reg <= 3'h0;
			fresh_reg <= 1'b0;
		end else begin
			wr_reg <= wr_reg + (go ? need[1:0] : 2'h0);
			rd_reg <= rd_reg + {1'b0, pop};
			cnt_reg <= cnt_reg + (go ? need : 3'h0) - {2'h0, pop}; // R16
			fresh_reg <= go && (new0 || new1);
		end
	end
	assign wb_valid = cnt_reg != 3'h0;
	assign wb_out = wbm[rd_reg];
	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_read_miss_stall: assert property (rmiss[0] |-> stall) else $error("read miss not stalled"); // R3
	a_no_write_alloc: assert property (st_reg == ST_IDLE && !rmiss_any |=> st_reg == ST_IDLE) // R4
		else $error("write left idle");
	a_victim_cancel: assert property ($rose(vic_pend_reg) |-> $past(inst)) else $error("bad victim"); // R6
	a_conflict_once: assert property (conf_stall |=> !conf_stall) else $error("conflict stall twice"); // R8
	a_rw_conflict: assert property (same_bank && ehit[0] && ehit[1] && acc0.write != acc1.write // R10
		&& !wmiss[0] && !wmiss[1] && !acc1.nalign && !conf_reg |-> conf_stall) else $error("missed rw stall");
	a_read_pair_ok: assert property (same_bank && same_word && !acc0.write && !acc1.write |-> !conf_stall) // R9
		else $error("same word reads stalled");
	// Widened by one bit so a saturated penalty counter cannot wrap to zero.
	a_min_penalty: assert property (st_reg == ST_FILL && st_next == ST_IDLE // R12
		|-> {1'b0, pen_reg} + 5'h01 >= {1'b0, pen_min}) else $error("miss too short");
	a_drain_first: assert property (fill_req_valid |-> cnt_reg == 3'h0 && !vic_pend_reg) // R18
		else $error("fill before drain");
	a_wbuf_bound: assert property (cnt_reg <= WB_DEPTH) else $error("write buffer overflow"); // R16
	a_full_stalls: assert property (wmiss[0] && new0 && cnt_reg == WB_DEPTH |-> stall ##1 cnt_reg >= 3'h3) // R17
		else $error("full buffer not stalled");
	c_conflict: cover property (conf_stall ##1 !stall);
	c_overlap: cover property (st_reg == ST_FILL && two_reg && fdone);
	c_merge: cover property (go && (mrg0 || mrg1 || pair));
	c_victim: cover property (vic_valid && vic_ready);
endmodule

// file: testbench/l1dc_far_model.sv
// Far side model: line fills, write buffer sink and victim sink.
`timescale 1ns/10ps
module l1dc_far_model
	import l1dc_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  fill_req_valid,
	input  wire logic [LINE_W-1:0]     fill_req_line,
	output logic                       fill_req_ready,
	output logic                       fill_beat_valid,
	output logic [63:0]                fill_beat_data,
	output logic                       fill_cacheable,
	output logic                       fill_sram,
	input  wire logic                  wb_valid,
	input  wire l1dc_wb_s              wb_out,
	output logic                       wb_ready,
	input  wire logic                  vic_valid,
	input  wire logic [LINE_W-1:0]     vic_line,
	input  wire logic [LINE_BYTES*8-1:0] vic_data,
	output logic                       vic_ready,
	input  wire logic                  far_hold,
	input  wire logic                  far_cacheable,
	output int                         n_fill,
	output int                         n_pop,
	output int                         n_vic
);
	logic [LINE_W-1:0] pend [$];
	logic [LINE_W-1:0] cur;
	logic [3:0]        beat;
	l1dc_wb_s          wb_log [0:15];
	logic [LINE_W-1:0] vic_seen;
	logic [31:0]       vic_word0;

	assign fill_req_ready = 1'b1;
	assign fill_sram      = 1'b1;
	assign vic_ready      = 1'b1;
	assign wb_ready       = !far_hold;

	// Every word of a fill carries its own byte address, so any read can be predicted.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pend.delete();
			beat = 4'h8;
			fill_beat_valid <= 1'b0;
			n_fill <= 0;
			n_pop <= 0;
			n_vic <= 0;
		end else begin
			if (fill_req_valid) begin
				pend.push_back(fill_req_line);
				n_fill <= n_fill + 1;
			end
			if (beat == 4'h8 && pend.size() > 0) begin
				cur = pend.pop_front();
				beat = 4'h0;
			end
			fill_beat_valid <= (beat < 4'h8);
			fill_cacheable <= (beat < 4'h8) ? far_cacheable : !far_cacheable;
			if (beat < 4'h8) begin
				fill_beat_data <= {cur, beat[2:0], 3'h4, cur, beat[2:0], 3'h0};
				beat = beat + 4'h1;
			end else begin
				fill_beat_data <= ~fill_beat_data;
			end
			if (wb_valid && wb_ready) begin
				wb_log[n_pop % 16] <= wb_out;
				n_pop <= n_pop + 1;
			end
			if (vic_valid) begin
				n_vic <= n_vic + 1;
				vic_seen <= vic_line;
				vic_word0 <= vic_data[31:0];
			end
		end
	end
endmodule

// file: testbench/l1_data_cache_with_write_buffer_test.sv
// Self-checking bench for the level one data cache.
`timescale 1ns/10ps
module l1_data_cache_with_write_buffer_test
	import l1dc_pkg::*;
;
	logic clk, rst, stall, rvalid0, rvalid1, wb_valid, wb_ready, fill_req_valid, fill_req_ready;
	logic fill_beat_valid, fill_cacheable, fill_sram, vic_valid, vic_ready, far_hold, far_cacheable;
	logic [31:0] rdata0, rdata1, rd0, rd1;
	logic rv0, rv1;
	logic [63:0] fill_beat_data;
	logic [LINE_W-1:0] fill_req_line, vic_line;
	logic [LINE_BYTES*8-1:0] vic_data;
	l1dc_acc_s acc0, acc1;
	l1dc_wb_s wb_out;
	int n_fill, n_pop, n_vic, n_checks, n_mismatch;

	l1dc_top u_l1dc_top (.clk(clk), .rst(rst), .acc0(acc0), .acc1(acc1), .stall(stall),
		.rvalid0(rvalid0), .rdata0(rdata0), .rvalid1(rvalid1), .rdata1(rdata1),
		.wb_valid(wb_valid), .wb_out(wb_out), .wb_ready(wb_ready), .fill_req_valid(fill_req_valid),
		.fill_req_line(fill_req_line), .fill_req_ready(fill_req_ready), .fill_beat_valid(fill_beat_valid),
		.fill_beat_data(fill_beat_data), .fill_cacheable(fill_cacheable), .fill_sram(fill_sram),
		.vic_valid(vic_valid), .vic_line(vic_line), .vic_data(vic_data), .vic_ready(vic_ready));
	l1dc_far_model u_l1dc_far_model (.clk(clk), .rst(rst), .fill_req_valid(fill_req_valid),
		.fill_req_line(fill_req_line), .fill_req_ready(fill_req_ready), .fill_beat_valid(fill_beat_valid),
		.fill_beat_data(fill_beat_data), .fill_cacheable(fill_cacheable), .fill_sram(fill_sram),
		.wb_valid(wb_valid), .wb_out(wb_out), .wb_ready(wb_ready), .vic_valid(vic_valid),
		.vic_line(vic_line), .vic_data(vic_data), .vic_ready(vic_ready), .far_hold(far_hold),
		.far_cacheable(far_cacheable), .n_fill(n_fill), .n_pop(n_pop), .n_vic(n_vic));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// ----
	// Shared tasks
	// ----
	task automatic complete_run();
		$display("Checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic l1dc_acc_s mk(input logic wr, input logic [31:0] a, input logic [3:0] be,
		input logic [31:0] d);
		mk = '0;
		mk.valid = 1'b1;
		mk.write = wr;
		mk.l2_sram = 1'b1;
		mk.addr = a;
		mk.be = be;
		mk.wdata = d;
	endfunction
	function automatic logic [31:0] pat(input logic [31:0] a);
		pat = {a[31:2], 2'h0};
	endfunction
	// Holds both accesses while stalled; the edge after stall is seen low takes them.
	task automatic acc(input l1dc_acc_s a0, input l1dc_acc_s a1, output int ns);
		ns = 0;
		@(posedge clk);
		acc0 <= a0;
		acc1 <= a1;
		@(negedge clk);
		while (stall !== 1'b0) begin
			ns++;
			if (ns > 300) begin
				n_mismatch++;
				$display("MISMATCH at %0t: stall never released", $time);
				complete_run();
			end
			@(negedge clk);
		end
		@(posedge clk);
		acc0 <= '0;
		acc1 <= '0;
		@(negedge clk);
		rv0 = rvalid0;
		rv1 = rvalid1;
		rd0 = rdata0;
		rd1 = rdata1;
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_miss_hit();
		int ns;
		int nf;
		acc(mk(0, 32'h40, 4'hF, 0), '0, ns);
		check(ns >= 6, 1);
		check(ns >= 9, 1);
		check({rv0, rd0}, {1'b1, pat(32'h40)});
		acc(mk(0, 32'h44, 4'hF, 0), mk(0, 32'h48, 4'hF, 0), ns);
		check(ns, 0);
		check({rv0, rd0, rv1}, {1'b1, pat(32'h44), 1'b1});
		check(rd1, pat(32'h48));
		nf = n_fill;
		acc(mk(0, 32'h80, 4'hF, 0), mk(0, 32'h84, 4'hF, 0), ns);
		check(n_fill - nf, 1);
		check(rd1, pat(32'h84));
		nf = n_fill;
		acc(mk(0, 32'h104, 4'hF, 0), mk(0, 32'h148, 4'hF, 0), ns);
		check(n_fill - nf, 2);
		check({rv0, rd0, rv1, rd1}, {1'b1, pat(32'h104), 1'b1, pat(32'h148)});
		$display("Test miss_hit done");
	endtask
	task automatic t_bank();
		int ns;
		l1dc_acc_s a;
		acc(mk(0, 32'h40, 4'hF, 0), mk(0, 32'h40, 4'h3, 0), ns);
		check(ns, 0);
		acc(mk(0, 32'h40, 4'hF, 0), mk(1, 32'h60, 4'hF, 32'h1111_2222), ns);
		check(ns, 1);
		acc(mk(1, 32'h44, 4'h1, 32'hAA), mk(1, 32'h44, 4'h2, 32'hBB00), ns);
		check(ns, 0);
		acc(mk(0, 32'h44, 4'hF, 0), mk(0, 32'h60, 4'hF, 0), ns);
		check(ns, 0);
		check({rd0, rd1}, {32'h0000_BBAA, 32'h1111_2222});
		acc(mk(1, 32'h48, 4'hF, 1), mk(1, 32'h68, 4'hF, 2), ns);
		check(ns, 1);
		a = mk(0, 32'h6C, 4'hF, 0);
		a.nalign = 1'b1;
		acc(mk(0, 32'h4C, 4'hF, 0), a, ns);
		check(ns, 0);
		acc(mk(0, 32'h40, 4'hF, 0), mk(1, 32'h2000, 4'hF, 5), ns);
		check(ns, 0);
		$display("Test bank done");
	endtask
	task automatic t_wbuf();
		int ns;
		int np;
		int nf;
		// Let the last write miss of the previous scenario leave the buffer first.
		repeat (2) @(posedge clk);
		far_hold <= 1'b1;
		np = n_pop;
		for (int i = 0; i < 4; i++) begin
			acc(mk(1, 32'h3000 + 8 * i, 4'hF, i + 1), '0, ns);
			check(ns, 0);
		end
		fork
			acc(mk(1, 32'h3020, 4'hF, 5), '0, ns);
			begin
				repeat (8) @(posedge clk);
				far_hold <= 1'b0;
			end
		join
		check({ns >= 6, ns <= 12}, 2'h3);
		repeat (8) @(posedge clk);
		check(n_pop - np, 5);
		check(u_l1dc_far_model.wb_log[np % 16].dw, 29'h600);
		check(u_l1dc_far_model.wb_log[(np + 1) % 16].be, 8'h0F);
		check(u_l1dc_far_model.wb_log[(np + 1) % 16].data[31:0], 32'h2);
		far_hold <= 1'b1;
		acc(mk(1, 32'h3028, 4'hF, 7), '0, ns);
		nf = n_fill;
		fork
			acc(mk(0, 32'h3000, 4'hF, 0), '0, ns);
			begin
				repeat (10) @(posedge clk);
				check(n_fill - nf, 0);
				far_hold <= 1'b0;
			end
		join
		check(ns >= 10, 1);
		check(rd0, pat(32'h3000));
		$display("Test wbuf done");
	endtask
	task automatic t_merge();
		int ns;
		int np;
		far_hold <= 1'b1;
		np = n_pop;
		acc(mk(1, 32'h5100, 4'hF, 9), '0, ns);
		acc(mk(1, 32'h5000, 4'hF, 32'hCAFE_0001), mk(1, 32'h5004, 4'hF, 32'hCAFE_0002), ns);
		check(ns, 0);
		far_hold <= 1'b0;
		repeat (6) @(posedge clk);
		check(n_pop - np, 2);
		check(u_l1dc_far_model.wb_log[(np + 1) % 16].be, 8'hFF);
		check(u_l1dc_far_model.wb_log[(np + 1) % 16].data, {32'hCAFE_0002, 32'hCAFE_0001});
		$display("Test merge done");
	endtask
	task automatic t_victim();
		int ns;
		int nv;
		nv = n_vic;
		acc(mk(1, 32'h80, 4'hF, 32'hA5A5_5A5A), '0, ns);
		acc(mk(0, 32'h2080, 4'hF, 0), '0, ns);
		acc(mk(0, 32'h80, 4'hF, 0), '0, ns);
		check({ns, rd0}, {32'h0, 32'hA5A5_5A5A});
		acc(mk(0, 32'h4080, 4'hF, 0), '0, ns);
		check(n_vic - nv, 0);
		far_cacheable <= 1'b0;
		acc(mk(0, 32'h6080, 4'hF, 0), '0, ns);
		check(rd0, pat(32'h6080));
		repeat (4) @(posedge clk);
		check(n_vic - nv, 0);
		acc(mk(0, 32'h80, 4'hF, 0), '0, ns);
		check(ns, 0);
		acc(mk(0, 32'h4080, 4'hF, 0), '0, ns);
		far_cacheable <= 1'b1;
		acc(mk(0, 32'h6080, 4'hF, 0), '0, ns);
		repeat (4) @(posedge clk);
		check(n_vic - nv, 1);
		check(u_l1dc_far_model.vic_seen, 26'h2);
		check(u_l1dc_far_model.vic_word0, 32'hA5A5_5A5A);
		$display("Test victim done");
	endtask

	initial begin
		n_checks = 0;
		n_mismatch = 0;
		rst = 1'b1;
		acc0 = '0;
		acc1 = '0;
		far_hold = 1'b0;
		far_cacheable = 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_miss_hit();
		t_bank();
		t_wbuf();
		t_merge();
		t_victim();
		complete_run();
	end
endmodule
